// ---- src/phy_reset_link_power_map.svh ----
// Register offsets, field positions, reset values and timing counts of the PHY reset and power control
// How it works
// - Writing one to reset_control bit 15 resets logic and register file; bit self-clears.
// - Writing one to reset_control bit 14 resets only the digital core; bit self-clears.
// - link_state_summary bit 15 reads one while the link monitor sees link up.
// - link_state_summary bit 14 reads one while the link monitor sees link down.
// - link_state_summary bit 13 shows the PHY control send-data state, read-only.
// - link_state_summary bit 12 shows the live link indication, never latched.
// - low_power_config bit 8 switches energy detection on the line interface.
// - low_power_config bit 7 permits sleep when one, forbids it when zero.
// - low_power_config bit 6 picks normal (one) or standby (zero) after a core reset; the strap picks at power up and after a full reset.
// - power_mode_request bit 4 moves to standby and clears itself when taken.
// - power_mode_request bit 0 moves to normal and clears itself when taken.
// - power_state_status code reads 2 in standby and 4 in normal.
`ifndef PHY_RESET_LINK_POWER_MAP_SVH
`define PHY_RESET_LINK_POWER_MAP_SVH

// Register indices; the byte address is four times the index
`define IDX_RESET_CONTROL       9'h01F
`define IDX_LINK_STATE_SUMMARY  9'h180
`define IDX_LOW_POWER_CONFIG    9'h18B
`define IDX_POWER_MODE_REQUEST  9'h18C
`define IDX_POWER_STATE_STATUS  9'h18E
`define IDX_EVENT_STATUS        9'h190
`define IDX_EVENT_MASK          9'h191

`define ADDR_WIDTH              12
`define ADDR_OF(idx)            ({1'b0, (idx), 2'b00})

// reset_control fields
`define BIT_FULL_RESET          15
`define BIT_CORE_RESET          14

// link_state_summary fields
`define BIT_LINK_UP             15
`define BIT_LINK_DOWN           14
`define BIT_SEND_DATA           13
`define BIT_LIVE_LINK           12
`define BIT_CHANNEL_OK          3
`define BIT_DESCR_SYNC          2
`define BIT_LOC_RCVR            1
`define BIT_REM_RCVR            0

// low_power_config fields
`define BIT_ENERGY_SENSE        8
`define BIT_SLEEP_ALLOW         7
`define BIT_AUTO_NORMAL         6

// power_mode_request fields
`define BIT_REQ_STANDBY         4
`define BIT_REQ_NORMAL          0

// power_state_status field
`define POWER_CODE_LSB          0
`define POWER_CODE_WIDTH        7
`define POWER_CODE_STANDBY      7'h02
`define POWER_CODE_NORMAL       7'h04
`define POWER_CODE_NONE         7'h00

// Event bits of the interrupt status and mask registers
`define EVT_LINK_UP             0
`define EVT_LINK_DOWN           1
`define EVT_POWER_CHANGE        2
`define EVT_RESET_DONE          3
`define EVT_COUNT               4

`define REG_RESET_VALUE         16'h0000
`define MASK_RESET_VALUE        4'h0

// Timing
`define CLK_PERIOD_NS           25
`define RST_PULSE_NS            100
`define RST_PULSE_CYC           ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_SETTLE_CYC        3

`endif

// ---- src/phy_reset_link_power_pkg.sv ----
// Types shared by the PHY reset and power control
package phy_reset_link_power_pkg;

   typedef enum logic [1:0] {
      ST_INIT    = 2'b00,
      ST_STANDBY = 2'b01,
      ST_NORMAL  = 2'b10
   } power_state_type;

endpackage

// ---- src/level_sync.sv ----
// Two-flop synchroniser for a group of unrelated levels
`timescale 1ns/1ps
module level_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             i_clk,
   input  wire logic             i_arst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   initial begin
      if (WIDTH < 1) begin
         $error("level_sync: WIDTH must be at least 1");
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;

endmodule

// ---- src/phy_reset_link_power_ctrl.sv ----
// PHY reset commands, link monitor status and low-power sequencer behind an APB slave
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "phy_reset_link_power_map.svh"
module phy_reset_link_power_ctrl
   import phy_reset_link_power_pkg::*;
#(
   parameter int unsigned RST_CYCLES   = `RST_PULSE_CYC,
   parameter int unsigned STRAP_SETTLE = `STRAP_SETTLE_CYC
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_arst_n,
   input  wire logic                   i_psel,
   input  wire logic                   i_penable,
   input  wire logic                   i_pwrite,
   input  wire logic [`ADDR_WIDTH-1:0] i_paddr,
   input  wire logic [31:0]            i_pwdata,
   output logic      [31:0]            o_prdata,
   output logic                        o_pready,
   output logic                        o_pslverr,
   input  wire logic                   i_link_up,
   input  wire logic                   i_link_down,
   input  wire logic                   i_send_data,
   input  wire logic                   i_live_link,
   input  wire logic                   i_channel_ok,
   input  wire logic                   i_descr_sync,
   input  wire logic                   i_loc_rcvr_ok,
   input  wire logic                   i_rem_rcvr_ok,
   input  wire logic                   i_auto_mode_strap,
   output logic                        o_full_chip_soft_reset,
   output logic                        o_digital_core_reset,
   output logic                        o_mdi_energy_sense_on,
   output logic                        o_sleep_allow,
   output logic                        o_power_normal,
   output logic                        o_power_standby,
   output logic                        o_irq
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks and helpers

   localparam int unsigned CNT_W = $clog2(RST_CYCLES + STRAP_SETTLE + 2);

   initial begin
      if (RST_CYCLES < 1) begin
         $error("RST_CYCLES must be at least 1");
      end
      if (STRAP_SETTLE < 3) begin
         $error("STRAP_SETTLE must cover the two-flop synchroniser");
      end
   end

   function automatic logic [`EVT_COUNT-1:0] sticky_next(input logic [`EVT_COUNT-1:0] cur,
                                                          input logic [`EVT_COUNT-1:0] set,
                                                          input logic [`EVT_COUNT-1:0] clr);
      sticky_next = (cur & ~clr) | set;
   endfunction

   function automatic logic addr_hit(input logic [`ADDR_WIDTH-1:0] addr, input logic [8:0] idx);
      addr_hit = (addr == `ADDR_OF(idx));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Input synchronisation

   logic [8:0] pins_sync;

   level_sync #(
      .WIDTH (9)
   ) u_pin_sync (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_async  ({i_auto_mode_strap, i_link_up, i_link_down, i_send_data, i_live_link,
                  i_channel_ok, i_descr_sync, i_loc_rcvr_ok, i_rem_rcvr_ok}),
      .o_sync   (pins_sync)
   );

   wire strap_s     = pins_sync[8];
   wire link_up_s   = pins_sync[7];
   wire link_down_s = pins_sync[6];

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // APB decode

   logic                        pready_q;
   logic                        pslverr_q;
   logic [31:0]                 prdata_q;

   wire access      = i_psel & i_penable;
   wire commit      = access & pready_q;
   wire wr_commit   = commit & i_pwrite;
   wire answer_now  = access & ~pready_q;
   wire hit_rst     = addr_hit(i_paddr, `IDX_RESET_CONTROL);
   wire hit_lss     = addr_hit(i_paddr, `IDX_LINK_STATE_SUMMARY);
   wire hit_cfg     = addr_hit(i_paddr, `IDX_LOW_POWER_CONFIG);
   wire hit_req     = addr_hit(i_paddr, `IDX_POWER_MODE_REQUEST);
   wire hit_pst     = addr_hit(i_paddr, `IDX_POWER_STATE_STATUS);
   wire hit_evs     = addr_hit(i_paddr, `IDX_EVENT_STATUS);
   wire hit_evm     = addr_hit(i_paddr, `IDX_EVENT_MASK);
   wire hit_any     = hit_rst | hit_lss | hit_cfg | hit_req | hit_pst | hit_evs | hit_evm;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Reset commands

   logic             full_q;
   logic             core_q;
   logic [CNT_W-1:0] rst_cnt_q;
   logic             reset_done_q;

   wire rst_busy    = core_q;
   wire wr_full     = wr_commit & hit_rst & i_pwdata[`BIT_FULL_RESET] & ~rst_busy;
   wire wr_core     = wr_commit & hit_rst & i_pwdata[`BIT_CORE_RESET] & ~rst_busy & ~i_pwdata[`BIT_FULL_RESET];
   wire rst_last    = rst_busy & (rst_cnt_q == CNT_W'(1));
   // Register file is held at reset values while the full reset runs
   wire regs_clr    = full_q;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         full_q       <= 1'b0;
         core_q       <= 1'b0;
         rst_cnt_q    <= '0;
         reset_done_q <= 1'b0;
      end else begin
         reset_done_q <= rst_last;
         if (wr_full || wr_core) begin
            full_q    <= wr_full;
            core_q    <= 1'b1;
            rst_cnt_q <= CNT_W'(RST_CYCLES);
         end else if (rst_last) begin
            full_q    <= 1'b0;
            core_q    <= 1'b0;
            rst_cnt_q <= '0;
         end else if (rst_busy) begin
            rst_cnt_q <= rst_cnt_q - CNT_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Low-power configuration and requests

   logic energy_q;
   logic sleep_q;
   logic auto_q;
   logic req_stby_q;
   logic req_norm_q;
   logic strap_load_q;
   power_state_type state_q;
   power_state_type state_d;
   logic [CNT_W-1:0] settle_q;

   wire wr_cfg      = wr_commit & hit_cfg & ~regs_clr;
   wire wr_req      = wr_commit & hit_req & ~regs_clr;
   wire settle_done = (state_q == ST_INIT) & ~rst_busy & (settle_q == CNT_W'(STRAP_SETTLE));
   wire req_taken   = (state_q != ST_INIT) & ~rst_busy;
   wire auto_eff    = strap_load_q ? strap_s : auto_q;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         energy_q     <= 1'b0;
         sleep_q      <= 1'b0;
         auto_q       <= 1'b0;
         strap_load_q <= 1'b1;
      end else if (regs_clr) begin
         energy_q     <= 1'b0;
         sleep_q      <= 1'b0;
         auto_q       <= 1'b0;
         strap_load_q <= 1'b1;
      end else begin
         if (wr_cfg) begin
            energy_q <= i_pwdata[`BIT_ENERGY_SENSE];
            sleep_q  <= i_pwdata[`BIT_SLEEP_ALLOW];
            auto_q   <= i_pwdata[`BIT_AUTO_NORMAL];
         end else if (settle_done && strap_load_q) begin
            auto_q   <= strap_s;
         end
         if (settle_done) begin
            strap_load_q <= 1'b0;
         end
      end
   end

   // A request written in the cycle it is taken survives: set wins over clear
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         req_stby_q <= 1'b0;
         req_norm_q <= 1'b0;
      end else if (regs_clr) begin
         req_stby_q <= 1'b0;
         req_norm_q <= 1'b0;
      end else begin
         if (wr_req && i_pwdata[`BIT_REQ_STANDBY]) begin
            req_stby_q <= 1'b1;
         end else if (req_taken) begin
            req_stby_q <= 1'b0;
         end
         if (wr_req && i_pwdata[`BIT_REQ_NORMAL]) begin
            req_norm_q <= 1'b1;
         end else if (req_taken) begin
            req_norm_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Power sequencer

   always_comb begin
      state_d = state_q;
      if (rst_busy) begin
         state_d = ST_INIT;
      end else begin
         case (state_q)
            ST_INIT: begin
               if (settle_done) begin
                  state_d = auto_eff ? ST_NORMAL : ST_STANDBY;
               end
            end
            ST_STANDBY,
            ST_NORMAL: begin
               if (req_stby_q) begin
                  state_d = ST_STANDBY;
               end else if (req_norm_q) begin
                  state_d = ST_NORMAL;
               end
            end
            default: begin
               state_d = ST_INIT;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q  <= ST_INIT;
         settle_q <= '0;
      end else begin
         state_q <= state_d;
         if (state_d != ST_INIT || rst_busy) begin
            settle_q <= '0;
         end else if (settle_q != CNT_W'(STRAP_SETTLE)) begin
            settle_q <= settle_q + CNT_W'(1);
         end
      end
   end

   wire [`POWER_CODE_WIDTH-1:0] power_code = (state_q == ST_STANDBY) ? `POWER_CODE_STANDBY :
                                             (state_q == ST_NORMAL)  ? `POWER_CODE_NORMAL  : `POWER_CODE_NONE;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Events and interrupt

   logic [`EVT_COUNT-1:0] evt_status_q;
   logic [`EVT_COUNT-1:0] evt_mask_q;
   logic                  link_up_prev_q;
   logic                  link_down_prev_q;
   logic                  irq_q;

   wire [`EVT_COUNT-1:0] evt_set;
   assign evt_set[`EVT_LINK_UP]      = link_up_s & ~link_up_prev_q;
   assign evt_set[`EVT_LINK_DOWN]    = link_down_s & ~link_down_prev_q;
   assign evt_set[`EVT_POWER_CHANGE] = (state_d != state_q) & (state_d != ST_INIT);
   assign evt_set[`EVT_RESET_DONE]   = reset_done_q;

   wire [`EVT_COUNT-1:0] evt_clr    = (wr_commit & hit_evs) ? i_pwdata[`EVT_COUNT-1:0] : '0;
   wire [`EVT_COUNT-1:0] evt_stat_d = regs_clr ? '0 : sticky_next(evt_status_q, evt_set, evt_clr);
   wire [`EVT_COUNT-1:0] evt_mask_d = regs_clr ? `MASK_RESET_VALUE :
                                      (wr_commit & hit_evm) ? i_pwdata[`EVT_COUNT-1:0] : evt_mask_q;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         evt_status_q     <= '0;
         evt_mask_q       <= `MASK_RESET_VALUE;
         link_up_prev_q   <= 1'b0;
         link_down_prev_q <= 1'b0;
         irq_q            <= 1'b0;
      end else begin
         evt_status_q     <= evt_stat_d;
         evt_mask_q       <= evt_mask_d;
         link_up_prev_q   <= link_up_s;
         link_down_prev_q <= link_down_s;
         irq_q            <= |(evt_stat_d & evt_mask_d);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Read data

   wire [15:0] rd_rst = {full_q, core_q & ~full_q, 14'h0000};
   wire [15:0] rd_lss = {pins_sync[7:4], 8'h00, pins_sync[3:0]};
   wire [15:0] rd_cfg = {7'h00, energy_q, sleep_q, auto_q, 6'h00};
   wire [15:0] rd_req = {11'h000, req_stby_q, 3'h0, req_norm_q};
   wire [15:0] rd_pst = {9'h000, power_code};
   wire [15:0] rd_evs = {12'h000, evt_status_q};
   wire [15:0] rd_evm = {12'h000, evt_mask_q};

   wire [15:0] rd_mux = hit_rst ? rd_rst :
                        hit_lss ? rd_lss :
                        hit_cfg ? rd_cfg :
                        hit_req ? rd_req :
                        hit_pst ? rd_pst :
                        hit_evs ? rd_evs :
                        hit_evm ? rd_evm : 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // APB answer: one wait state, pready high in the second access cycle

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= answer_now;
         pslverr_q <= answer_now & ~hit_any;
         if (answer_now && !i_pwrite) begin
            prdata_q <= {16'h0000, rd_mux};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Output ports, each straight from a flop

   assign o_prdata               = prdata_q;
   assign o_pready               = pready_q;
   assign o_pslverr              = pslverr_q;
   assign o_full_chip_soft_reset = full_q;
   assign o_digital_core_reset   = core_q;
   assign o_mdi_energy_sense_on  = energy_q;
   assign o_sleep_allow          = sleep_q;
   // Standby and normal codes each own one bit of the state register
   assign o_power_normal         = state_q[1];
   assign o_power_standby        = state_q[0];
   assign o_irq                  = irq_q;

endmodule

// ---- testbench/phy_reset_link_power_checker.sv ----
// Concurrent checks on the ports of the PHY reset and power control block
`timescale 1ns/1ps
`include "phy_reset_link_power_map.svh"
module phy_reset_link_power_checker #(
   parameter int unsigned RST_CYCLES = 4
) (
   input wire logic        i_clk,
   input wire logic        i_arst_n,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        o_full_chip_soft_reset,
   input wire logic        o_digital_core_reset,
   input wire logic        o_mdi_energy_sense_on,
   input wire logic        o_sleep_allow,
   input wire logic        o_power_normal,
   input wire logic        o_power_standby,
   input wire logic        o_irq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   logic [7:0] run_q;
   logic       wr_done;
   assign wr_done = i_psel && i_penable && i_pwrite && o_pready;
   // Counts the cycles of the full reset pulse
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         run_q <= 8'h00;
      end else begin
         run_q <= o_full_chip_soft_reset ? run_q + 8'h01 : 8'h00;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   sequence s_first_access;
      i_psel && i_penable && !$past(i_penable);
   endsequence
   sequence s_one_wait;
      !o_pready ##1 o_pready;
   endsequence
   property p_one_wait;          s_first_access |-> s_one_wait; endproperty
   property p_ready_in_access;   o_pready |-> i_psel && i_penable; endproperty
   property p_ready_pulse;       o_pready |=> !o_pready; endproperty
   property p_err_with_ready;    o_pslverr |-> o_pready; endproperty
   property p_upper_zero;        o_pready |-> o_prdata[31:16] == 16'h0000; endproperty
   property p_full_len;          $fell(o_full_chip_soft_reset) |-> run_q == RST_CYCLES; endproperty
   property p_full_has_core;     o_full_chip_soft_reset |-> o_digital_core_reset; endproperty
   property p_full_clears;
      $rose(o_full_chip_soft_reset) |-> ##3 (!o_mdi_energy_sense_on && !o_sleep_allow && !o_irq);
   endproperty
   property p_core_to_init;
      $rose(o_digital_core_reset) |-> ##[0:2] (!o_power_normal && !o_power_standby);
   endproperty
   property p_cfg_hold;
      !wr_done && !o_full_chip_soft_reset |=> $stable(o_mdi_energy_sense_on) && $stable(o_sleep_allow);
   endproperty
   property p_one_state;         !(o_power_normal && o_power_standby); endproperty
   a_one_wait:        assert property (p_one_wait) else $error("pready not after one wait state");
   a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access phase");
   a_ready_pulse:     assert property (p_ready_pulse) else $error("pready longer than one cycle");
   a_err_with_ready:  assert property (p_err_with_ready) else $error("pslverr without pready");
   a_upper_zero:      assert property (p_upper_zero) else $error("read data upper half not zero");
   a_full_len:        assert property (p_full_len) else $error("full reset pulse length wrong");
   a_full_has_core:   assert property (p_full_has_core) else $error("full reset without core reset");
   a_full_clears:     assert property (p_full_clears) else $error("full reset left config set");
   a_core_to_init:    assert property (p_core_to_init) else $error("core reset kept power state");
   a_cfg_hold:        assert property (p_cfg_hold) else $error("config output moved without write");
   a_one_state:       assert property (p_one_state) else $error("normal and standby together");
endmodule
bind phy_reset_link_power_ctrl phy_reset_link_power_checker #(.RST_CYCLES(RST_CYCLES)) u_phy_reset_link_power_checker (
   .i_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .o_prdata, .o_pready, .o_pslverr,
   .o_full_chip_soft_reset, .o_digital_core_reset, .o_mdi_energy_sense_on, .o_sleep_allow,
   .o_power_normal, .o_power_standby, .o_irq);

// ---- testbench/phy_reset_link_power_ctrl_test.sv ----
// Self-checking bench of the PHY reset and power control block
`timescale 1ns/1ps
`include "phy_reset_link_power_map.svh"
module phy_reset_link_power_ctrl_test;
   import phy_reset_link_power_pkg::*;
   localparam logic [11:0] A_RC  = `ADDR_OF(`IDX_RESET_CONTROL);
   localparam logic [11:0] A_LSS = `ADDR_OF(`IDX_LINK_STATE_SUMMARY);
   localparam logic [11:0] A_LPC = `ADDR_OF(`IDX_LOW_POWER_CONFIG);
   localparam logic [11:0] A_PMR = `ADDR_OF(`IDX_POWER_MODE_REQUEST);
   localparam logic [11:0] A_PSS = `ADDR_OF(`IDX_POWER_STATE_STATUS);
   localparam logic [11:0] A_EVS = `ADDR_OF(`IDX_EVENT_STATUS);
   localparam logic [11:0] A_EVM = `ADDR_OF(`IDX_EVENT_MASK);
   logic        i_clk = 1'b0;
   logic        i_arst_n = 1'b0;
   logic        i_psel = 1'b0;
   logic        i_penable = 1'b0;
   logic        i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0;
   logic        i_auto_mode_strap = 1'b1;
   logic [7:0]  lnk = 8'h00;
   wire  [31:0] o_prdata;
   wire         o_pready, o_pslverr, o_full_chip_soft_reset, o_digital_core_reset;
   wire         o_mdi_energy_sense_on, o_sleep_allow, o_power_normal, o_power_standby, o_irq;
   logic [31:0] rdat;
   logic        rerr;
   int          error_cnt = 0;
   int          n_tests = 0;

   always #12.5 i_clk = ~i_clk;

   phy_reset_link_power_ctrl #(.RST_CYCLES(4), .STRAP_SETTLE(3)) u_phy_reset_link_power_ctrl (
      .i_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
      .i_link_up(lnk[7]), .i_link_down(lnk[6]), .i_send_data(lnk[5]), .i_live_link(lnk[4]),
      .i_channel_ok(lnk[3]), .i_descr_sync(lnk[2]), .i_loc_rcvr_ok(lnk[1]), .i_rem_rcvr_ok(lnk[0]),
      .i_auto_mode_strap, .o_full_chip_soft_reset, .o_digital_core_reset, .o_mdi_energy_sense_on,
      .o_sleep_allow, .o_power_normal, .o_power_standby, .o_irq);
   ////////////////////////////////////////////////////////////////////////
   task report_and_stop;
      $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask
   task idle(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // One APB transfer; waits for pready under a bound
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge i_clk);
      i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= wr; i_paddr <= a; i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      rdat = o_prdata;
      rerr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (n >= 20) chk("pready", 32'h1, 32'h0);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, rdat);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset_values;
      rd("reset_control", A_RC, 32'h0);
      rd("low_power_config", A_LPC, 32'h40);
      rd("power_state", A_PSS, 32'h4);
      rd("power_request", A_PMR, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, rerr});
      chk("unmapped_data", 32'h0, rdat);
      $display("test reset_values done");
   endtask
   task t_link_irq;
      lnk <= 8'hBA;
      idle(5);
      rd("link_state", A_LSS, 32'hB00A);
      chk("irq_masked", 32'h0, {31'h0, o_irq});
      wr(A_EVM, 32'h1);
      idle(3);
      chk("irq_on", 32'h1, {31'h0, o_irq});
      lnk <= 8'h45;
      idle(5);
      rd("link_state", A_LSS, 32'h4005);
      wr(A_EVS, 32'h1);
      idle(3);
      chk("irq_clear", 32'h0, {31'h0, o_irq});
      $display("test link_irq done");
   endtask
   task t_config;
      wr(A_LPC, 32'hFFFF);
      rd("low_power_config", A_LPC, 32'h1C0);
      chk("energy_on", 32'h1, {31'h0, o_mdi_energy_sense_on});
      chk("sleep_on", 32'h1, {31'h0, o_sleep_allow});
      wr(A_LSS, 32'hFFFF);
      rd("link_state_ro", A_LSS, 32'h4005);
      wr(A_LPC, 32'h0);
      idle(1);
      chk("energy_off", 32'h0, {31'h0, o_mdi_energy_sense_on});
      chk("sleep_off", 32'h0, {31'h0, o_sleep_allow});
      $display("test config done");
   endtask
   task t_power;
      wr(A_PMR, 32'hFFFF);
      idle(3);
      rd("request_clear", A_PMR, 32'h0);
      rd("state_standby", A_PSS, 32'h2);
      chk("out_standby", 32'h1, {31'h0, o_power_standby});
      wr(A_PMR, 32'h1);
      idle(3);
      rd("request_clear", A_PMR, 32'h0);
      rd("state_normal", A_PSS, 32'h4);
      chk("out_normal", 32'h1, {31'h0, o_power_normal});
      $display("test power done");
   endtask
   task t_core_reset;
      wr(A_LPC, 32'h100);
      wr(A_RC, 32'h4000);
      idle(1);
      chk("core_rst_out", 32'h1, {31'h0, o_digital_core_reset});
      chk("core_no_full", 32'h0, {31'h0, o_full_chip_soft_reset});
      idle(11);
      rd("core_self_clear", A_RC, 32'h0);
      rd("core_keeps_regs", A_LPC, 32'h100);
      rd("core_auto_standby", A_PSS, 32'h2);
      $display("test core_reset done");
   endtask
   task t_full_reset;
      wr(A_EVM, 32'hF);
      wr(A_LPC, 32'h180);
      wr(A_RC, 32'hC000);
      idle(1);
      chk("full_rst_out", 32'h1, {31'h0, o_full_chip_soft_reset});
      chk("full_core_out", 32'h1, {31'h0, o_digital_core_reset});
      idle(13);
      rd("full_self_clear", A_RC, 32'h0);
      rd("full_clears_cfg", A_LPC, 32'h40);
      rd("full_clears_mask", A_EVM, 32'h0);
      rd("full_strap_normal", A_PSS, 32'h4);
      $display("test full_reset done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      idle(2);
      i_arst_n <= 1'b1;
      idle(8);
      t_reset_values();
      t_link_irq();
      t_config();
      t_power();
      t_core_reset();
      t_full_reset();
      report_and_stop();
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      error_cnt++;
      report_and_stop();
   end
endmodule
